// ### shared/tpc_pkg.sv
package tpc_pkg;
    localparam int CLK_MHZ = 250;
    localparam int CLK_HZ = CLK_MHZ * 1000000;
    localparam int TURN_ON_TIME_US = 10000;
    localparam int CHANNEL_SWITCH_TIME_US = 1500;
    localparam int TURN_ON_CYC = TURN_ON_TIME_US * CLK_MHZ;
    localparam int CHANNEL_SWITCH_CYC = CHANNEL_SWITCH_TIME_US * CLK_MHZ;
    localparam int MIN_BPS = 100;
    localparam int MAX_BPS = 56000;
    localparam int MIN_BIT_CYC = (CLK_HZ + MAX_BPS - 1) / MAX_BPS;
    localparam int MAX_BIT_CYC = CLK_HZ / MIN_BPS;
    localparam int CNT_W = 22;
    // serial channel numbering
    localparam logic [6:0] SER_DEFAULT_CHAN = 7'h32;
    localparam logic [6:0] SER_ERROR_CHAN = 7'h00;
    localparam logic [7:0] SER_MAX_CHAN = 8'h64;
    localparam logic [3:0] SER_BITS = 4'h8;
    // host register map
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_DATA = 4'h8;
    localparam logic [3:0] OFS_BITDIV = 4'hc;
    localparam int CTRL_POWER_EN = 0;
    localparam int CTRL_MODE_SER = 1;
    localparam int CTRL_FLOAT_PD = 2;
    localparam int CTRL_SEL_LSB = 4;
    localparam int STAT_CTS = 0;
    localparam int STAT_FULL = 1;
    localparam int STAT_EMPTY = 2;
    localparam int STAT_BUSY = 3;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] BITDIV_RESET = 32'h0000_1171;
    typedef enum logic [1:0] {TPC_IDLE, TPC_BUSY_UNUSED} tpc_dummy_t;
    typedef enum {DEV_OFF, DEV_SAMPLE, DEV_LOCK, DEV_READY, DEV_SETTLE} tpc_dev_state_t;
endpackage

// ### shared/tpc_link_if.sv
`timescale 1ns/1ps
interface tpc_link_if;
    logic power_down_n_o;
    logic power_down_n_oe;
    logic mode_o;
    logic mode_oe;
    logic [2:0] chan_sel;
    logic data;
    logic cts;
    logic power_down_n;
    logic mode;
    // internal pull-ups on the device: an undriven pin reads high
    assign power_down_n = power_down_n_oe ? power_down_n_o : 1'b1;
    assign mode = mode_oe ? mode_o : 1'b1;
    modport dev (input power_down_n, input mode, input chan_sel, input data, output cts);
    modport host (output power_down_n_o, output power_down_n_oe, output mode_o,
        output mode_oe, output chan_sel, output data, input cts);
endinterface

// ### hdl/tpc_device.sv
`timescale 1ns/1ps
module tpc_device #(
    parameter int LOCK_CYC = tpc_pkg::TURN_ON_CYC - 16,
    parameter int SETTLE_CYC = tpc_pkg::CHANNEL_SWITCH_CYC - 16
) (
    // clock and supply
    input wire logic hclk,
    input wire logic hresetn,
    // pins
    tpc_link_if.dev link,
    // synthesizer and rf side
    output logic rf_on,
    output logic rf_data,
    output logic [6:0] synth_chan,
    output logic locked
);
    import tpc_pkg::*;

    // parallel code to serial channel index of the same frequency
    function automatic logic [6:0] par_chan(input logic [2:0] sel);
        logic [6:0] c;
        c = 7'h00;
        unique case (sel)
            3'h0: c = 7'h03;
            3'h1: c = 7'h0f;
            3'h2: c = 7'h15;
            3'h3: c = 7'h1b;
            3'h4: c = 7'h27;
            3'h5: c = 7'h33;
            3'h6: c = 7'h45;
            3'h7: c = 7'h4b;
        endcase
        return c;
    endfunction

    logic [5:0] sync1;
    logic [5:0] sync2;
    logic pd_n_s;
    logic mode_s;
    logic [2:0] sel_s;
    logic data_s;
    logic sclk_d;
    logic sdat_d;
    logic pd_n_d;
    tpc_dev_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [6:0] ser_chan;
    logic [7:0] ser_sh;
    logic [3:0] ser_cnt;
    logic ser_act;
    logic [6:0] want_chan;
    logic sclk_rise;
    logic load_done;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1 <= 6'h3f;
            sync2 <= 6'h3f;
        end else begin
            sync1 <= {link.power_down_n, link.mode, link.chan_sel, link.data};
            sync2 <= sync1;
        end
    end

    assign pd_n_s = sync2[5];
    assign mode_s = sync2[4];
    assign sel_s = sync2[3:1];
    assign data_s = sync2[0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sclk_d <= 1'b1;
            sdat_d <= 1'b1;
            pd_n_d <= 1'b1;
        end else begin
            sclk_d <= sel_s[1];
            sdat_d <= sel_s[2];
            pd_n_d <= pd_n_s;
        end
    end

    assign sclk_rise = sel_s[1] && !sclk_d;
    // both lines high again after the eighth bit latches the number
    assign load_done = ser_act && ser_cnt == SER_BITS && sel_s[1] && sel_s[2]
        && !(sclk_d && sdat_d);

    // serial port on select bits 1 (clock) and 2 (data), lsb first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ser_chan <= SER_DEFAULT_CHAN;
            ser_sh <= 8'h00;
            ser_cnt <= 4'h0;
            ser_act <= 1'b0;
        end else if (state == DEV_OFF || !mode_s) begin
            ser_chan <= SER_DEFAULT_CHAN;
            ser_act <= 1'b0;
            ser_cnt <= 4'h0;
        end else if (sel_s[1] && sclk_d && sdat_d && !sel_s[2]) begin
            ser_act <= 1'b1;
            ser_cnt <= 4'h0;
        end else if (load_done) begin
            ser_act <= 1'b0;
            ser_chan <= (ser_sh > SER_MAX_CHAN) ? SER_ERROR_CHAN : ser_sh[6:0];
        end else if (ser_act && sclk_rise && ser_cnt < SER_BITS) begin
            ser_sh <= {sel_s[2], ser_sh[7:1]};
            ser_cnt <= ser_cnt + 4'h1;
        end
    end

    // parallel mode only when mode is grounded
    assign want_chan = mode_s ? ser_chan : par_chan(sel_s);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= DEV_SAMPLE;
            cnt <= '0;
        end else if (!pd_n_s) begin
            state <= DEV_OFF;
            cnt <= '0;
        end else begin
            unique case (state)
                DEV_OFF: begin
                    // pull-up keeps an open pin active
                    if (pd_n_d) begin
                        state <= DEV_SAMPLE;
                    end
                end
                DEV_SAMPLE: begin
                    state <= DEV_LOCK;
                    cnt <= '0;
                end
                DEV_LOCK: begin
                    if (cnt == CNT_W'(LOCK_CYC - 1)) begin
                        state <= DEV_READY;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                DEV_READY: begin
                    if (want_chan != synth_chan) begin
                        state <= DEV_SETTLE;
                        cnt <= '0;
                    end
                end
                DEV_SETTLE: begin
                    if (want_chan != synth_chan) begin
                        cnt <= '0;
                    end else if (cnt == CNT_W'(SETTLE_CYC - 1)) begin
                        state <= DEV_READY;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
            endcase
        end
    end

    // the synthesizer word is loaded here, never by the host
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            synth_chan <= 7'h00;
        end else if (pd_n_s && (state == DEV_SAMPLE || state == DEV_READY
            || state == DEV_SETTLE)) begin
            synth_chan <= want_chan;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link.cts <= 1'b0;
            locked <= 1'b0;
        end else begin
            link.cts <= pd_n_s && state == DEV_READY && want_chan == synth_chan;
            locked <= pd_n_s && state == DEV_READY;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rf_on <= 1'b0;
            rf_data <= 1'b0;
        end else begin
            rf_on <= pd_n_s && state != DEV_OFF;
            // no framing or coding: the level goes straight to the modulator
            rf_data <= pd_n_s && state != DEV_OFF && data_s;
        end
    end
endmodule

// ### hdl/tpc_host.sv
`timescale 1ns/1ps
module tpc_fifo #(
    parameter int W = 32,
    parameter int D = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic push;
    logic pop;
    assign in_ready = cnt != (AW+1)'(D);
    assign out_valid = cnt != '0;
    assign out_data = mem[rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_ff @(posedge hclk) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            wp <= push ? AW'((wp + 1'b1) % D) : wp;
            rp <= pop ? AW'((rp + 1'b1) % D) : rp;
            cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module tpc_host #(
    parameter int FIFO_DEPTH = 32
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // pins
    tpc_link_if.host link
);
    import tpc_pkg::*;

    logic [2:0] cts_sync;
    logic [31:0] ctrl;
    logic [31:0] bitdiv;
    logic wr_pend;
    logic data_pend;
    logic [3:0] wr_ofs;
    logic f_in_ready;
    logic f_out_valid;
    logic f_out_ready;
    logic [31:0] f_out_data;
    logic [31:0] sh;
    logic [5:0] bits_left;
    logic [CNT_W-1:0] bit_cnt;
    logic [31:0] bit_per;
    logic addr_ok;

    assign addr_ok = hsel && htrans[1] && hready;

    // cts comes from the device's domain
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cts_sync <= 3'h0;
        end else begin
            cts_sync <= {cts_sync[1:0], link.cts};
        end
    end

    // data writes always take at least one wait state so a full fifo can stall the bus
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            data_pend <= 1'b0;
            wr_ofs <= 4'h0;
            hreadyout <= 1'b1;
        end else if (data_pend) begin
            if (f_in_ready) begin
                data_pend <= 1'b0;
                hreadyout <= 1'b1;
            end
        end else begin
            wr_pend <= addr_ok && hwrite && haddr[3:0] != OFS_DATA;
            data_pend <= addr_ok && hwrite && haddr[3:0] == OFS_DATA;
            hreadyout <= !(addr_ok && hwrite && haddr[3:0] == OFS_DATA);
            wr_ofs <= haddr[3:0];
        end
    end

    // host keeps the bit period inside the legal data-rate window
    assign bit_per = (hwdata < MIN_BIT_CYC) ? 32'(MIN_BIT_CYC) :
        (hwdata > MAX_BIT_CYC) ? 32'(MAX_BIT_CYC) : hwdata;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= CTRL_RESET;
            bitdiv <= BITDIV_RESET;
        end else if (wr_pend && wr_ofs == OFS_CTRL) begin
            ctrl <= hwdata;
        end else if (wr_pend && wr_ofs == OFS_BITDIV) begin
            bitdiv <= bit_per;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            unique case (haddr[3:0])
                OFS_CTRL: hrdata <= ctrl;
                OFS_STATUS: hrdata <= {28'h0000000, bits_left != 6'h00,
                    !f_out_valid, !f_in_ready, cts_sync[2]};
                OFS_BITDIV: hrdata <= bitdiv;
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    assign hresp = 1'b0;

    tpc_fifo #(.W(32), .D(FIFO_DEPTH)) i_tpc_fifo (
        .hclk(hclk),
        .hresetn(hresetn),
        .in_valid(data_pend),
        .in_ready(f_in_ready),
        .in_data(hwdata),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out_data)
    );

    // a word starts only while cts is high; a word in progress finishes
    assign f_out_ready = bits_left == 6'h00 && cts_sync[2] && ctrl[CTRL_POWER_EN];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sh <= 32'h0000_0000;
            bits_left <= 6'h00;
            bit_cnt <= '0;
        end else if (f_out_valid && f_out_ready) begin
            sh <= f_out_data;
            bits_left <= 6'h20;
            bit_cnt <= '0;
        end else if (bits_left != 6'h00) begin
            if (bit_cnt == CNT_W'(bitdiv - 32'h1)) begin
                bit_cnt <= '0;
                sh <= {1'b0, sh[31:1]};
                bits_left <= bits_left - 6'h01;
            end else begin
                bit_cnt <= bit_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link.power_down_n_o <= 1'b0;
            link.power_down_n_oe <= 1'b1;
            link.mode_o <= 1'b0;
            link.mode_oe <= 1'b1;
            link.chan_sel <= 3'h0;
            link.data <= 1'b0;
        end else begin
            // dropping power_en turns the transmitter off between bursts while CTRL_FLOAT_PD is clear
            link.power_down_n_o <= ctrl[CTRL_POWER_EN];
            link.power_down_n_oe <= !ctrl[CTRL_FLOAT_PD];
            link.mode_o <= ctrl[CTRL_MODE_SER];
            link.mode_oe <= 1'b1;
            link.chan_sel <= ctrl[CTRL_SEL_LSB +: 3];
            link.data <= bits_left != 6'h00 && sh[0];
        end
    end
endmodule

// ### dv/tpc_link_chk.sv
`timescale 1ns/1ps
module tpc_link_chk #(
    parameter int LOCK_CYC = 20
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // pins
    input wire logic power_down_n,
    input wire logic mode,
    input wire logic [2:0] chan_sel,
    input wire logic data,
    input wire logic cts,
    // device side
    input wire logic rf_on,
    input wire logic rf_data,
    input wire logic [6:0] synth_chan,
    input wire logic locked
);
    localparam int LIM = LOCK_CYC + 12;
    localparam logic [6:0] CHMAP [8] = '{7'h03, 7'h0f, 7'h15, 7'h1b, 7'h27, 7'h33, 7'h45, 7'h4b};
    // one counter covers start-up and channel change: settling is the shorter of the two
    logic [7:0] wait_cyc;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_cyc <= 8'h00;
        end else if (!power_down_n || cts || $changed(chan_sel) || $changed(mode)) begin
            wait_cyc <= 8'h00;
        end else if (wait_cyc != 8'hff) begin
            wait_cyc <= wait_cyc + 8'h01;
        end
    end
    property p_off_quiet;
        (!power_down_n) [*5] |-> !rf_on && !cts && !rf_data;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("active while off");
    property p_pd_fall;
        $fell(power_down_n) |-> ##[1:5] !cts;
    endproperty
    a_pd_fall: assert property (p_pd_fall) else $error("cts kept after power down");
    property p_startup_low;
        $rose(power_down_n) |-> !cts [*8];
    endproperty
    a_startup_low: assert property (p_startup_low) else $error("cts during start-up");
    property p_cts_locked;
        cts |-> locked || $past(locked);
    endproperty
    a_cts_locked: assert property (p_cts_locked) else $error("cts without lock");
    property p_turn_on;
        wait_cyc <= LIM;
    endproperty
    a_turn_on: assert property (p_turn_on) else $error("cts late");
    property p_drop_on_change;
        cts && !mode && $changed(chan_sel) |-> ##[1:5] !cts;
    endproperty
    a_drop_on_change: assert property (p_drop_on_change) else $error("cts kept on change");
    property p_par_chan;
        cts && !mode && chan_sel == $past(chan_sel, 5) |-> synth_chan == CHMAP[chan_sel];
    endproperty
    a_par_chan: assert property (p_par_chan) else $error("wrong parallel channel");
    property p_pass;
        rf_on && $past(rf_on, 3) |-> rf_data == $past(data, 3);
    endproperty
    a_pass: assert property (p_pass) else $error("data not passed through");
endmodule

// ### dv/tx_power_channel_control_tb.sv
`timescale 1ns/1ps
module tx_power_channel_control_tb;
    import tpc_pkg::*;
    localparam int LOCK = 20;
    localparam int SETTLE = 10;
    localparam logic [6:0] CHMAP [8] = '{7'h03, 7'h0f, 7'h15, 7'h1b, 7'h27, 7'h33, 7'h45, 7'h4b};
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rf_on, rf_data, locked;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [6:0] synth_chan;
    int err_total, total_checks;
    tpc_link_if i_tpc_link_if ();
    tpc_host #(.FIFO_DEPTH(32)) i_tpc_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .link(i_tpc_link_if.host));
    tpc_device #(.LOCK_CYC(LOCK), .SETTLE_CYC(SETTLE)) i_tpc_device (.hclk(hclk),
        .hresetn(hresetn), .link(i_tpc_link_if.dev), .rf_on(rf_on), .rf_data(rf_data),
        .synth_chan(synth_chan), .locked(locked));
    tpc_link_chk #(.LOCK_CYC(LOCK)) i_tpc_link_chk (.hclk(hclk), .hresetn(hresetn),
        .power_down_n(i_tpc_link_if.power_down_n), .mode(i_tpc_link_if.mode),
        .chan_sel(i_tpc_link_if.chan_sel), .data(i_tpc_link_if.data), .cts(i_tpc_link_if.cts),
        .rf_on(rf_on), .rf_data(rf_data), .synth_chan(synth_chan), .locked(locked));
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    task conclude;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task hang(input string name);
        err_total++;
        $display("mismatch %s expected done seen timeout", name);
        conclude();
    endtask
    task wait_ready;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 200) hang("hready");
            @(posedge hclk);
        end
    endtask
    // one single word transfer; read data lands in rd
    task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask
    task wait_cts(input logic v, input int lim);
        int n;
        n = 0;
        while (i_tpc_link_if.cts !== v) begin
            n++;
            if (n > lim) hang("cts");
            @(posedge hclk);
        end
    endtask
    task t_regs;
        ahb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl", rd, CTRL_RESET);
        ahb(1'b0, OFS_BITDIV, 32'h0);
        chk("bitdiv", rd, BITDIV_RESET);
        ahb(1'b1, OFS_BITDIV, 32'h0);
        ahb(1'b0, OFS_BITDIV, 32'h0);
        chk("bitdiv clamp", rd, BITDIV_RESET);
        ahb(1'b1, OFS_STATUS, 32'hf);
        ahb(1'b0, OFS_STATUS, 32'h0);
        chk("status", rd, 32'h1 << STAT_EMPTY);
        // only the low offset bits are decoded, so the write-only data word stands in
        ahb(1'b0, OFS_DATA, 32'h0);
        chk("data reads zero", rd, 32'h0);
        chk("hresp", hresp, 1'b0);
        chk("cts off", i_tpc_link_if.cts, 1'b0);
    endtask
    // transmitter is off, so nothing drains: the buffer must refuse at 32
    task t_fill;
        for (int i = 0; i < 32; i++) ahb(1'b1, OFS_DATA, 32'h1 | (i << 8));
        ahb(1'b0, OFS_STATUS, 32'h0);
        chk("full", rd[3:0], 4'b0010);
    endtask
    task t_chan;
        for (int c = 0; c < 8; c++) begin
            ahb(1'b1, OFS_CTRL, 32'h1 | (c << CTRL_SEL_LSB));
            if (c > 0) wait_cts(1'b0, 10);
            wait_cts(1'b1, (c == 0) ? LOCK + 16 : SETTLE + 16);
            chk("synth chan", synth_chan, CHMAP[c]);
            chk("locked", locked, 1'b1);
            chk("rf on", rf_on, 1'b1);
        end
        repeat (4) @(posedge hclk);
        chk("data pin", i_tpc_link_if.data, 1'b1);
        chk("rf data", rf_data, 1'b1);
        ahb(1'b0, OFS_STATUS, 32'h0);
        chk("status on", rd[3:0], 4'b1001);
    endtask
    task t_pdn;
        ahb(1'b1, OFS_CTRL, 32'h50);
        wait_cts(1'b0, 10);
        repeat (6) @(posedge hclk);
        chk("pin low", i_tpc_link_if.power_down_n, 1'b0);
        chk("rf off", rf_on, 1'b0);
        chk("rf data off", rf_data, 1'b0);
        ahb(1'b1, OFS_CTRL, 32'h54);
        wait_cts(1'b1, LOCK + 16);
        chk("pin float", i_tpc_link_if.power_down_n, 1'b1);
        chk("synth chan", synth_chan, CHMAP[5]);
    endtask
    task t_ser;
        ahb(1'b1, OFS_CTRL, 32'h2);
        wait_cts(1'b0, 10);
        ahb(1'b1, OFS_CTRL, 32'h3);
        wait_cts(1'b1, LOCK + 16);
        chk("mode pin", i_tpc_link_if.mode, 1'b1);
        chk("default chan", synth_chan, SER_DEFAULT_CHAN);
    endtask
    // software bit-bangs sel bit 1 (clock) and bit 2 (data), lsb first; 101 is out of range
    task t_ser_load;
        logic [7:0] v;
        for (int k = 0; k < 2; k++) begin
            v = (k == 0) ? 8'h21 : 8'h65;
            ahb(1'b1, OFS_CTRL, 32'h63);
            ahb(1'b1, OFS_CTRL, 32'h23);
            for (int b = 0; b < 8; b++) begin
                ahb(1'b1, OFS_CTRL, v[b] ? 32'h43 : 32'h03);
                ahb(1'b1, OFS_CTRL, v[b] ? 32'h63 : 32'h23);
            end
            ahb(1'b1, OFS_CTRL, 32'h03);
            ahb(1'b1, OFS_CTRL, 32'h63);
            wait_cts(1'b0, 10);
            wait_cts(1'b1, SETTLE + 16);
            chk("serial chan", synth_chan, (k == 0) ? 32'h21 : SER_ERROR_CHAN);
        end
    endtask
    // supply re-applied mid-run: buffer emptied and start-up repeated
    task t_reset;
        hresetn <= 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("cts reset", i_tpc_link_if.cts, 1'b0);
        ahb(1'b0, OFS_STATUS, 32'h0);
        chk("status reset", rd[3:0], 4'b0100);
        ahb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl reset", rd, CTRL_RESET);
        ahb(1'b1, OFS_CTRL, 32'h71);
        wait_cts(1'b1, LOCK + 16);
        chk("synth chan", synth_chan, CHMAP[7]);
    endtask
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        err_total = 0;
        total_checks = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_fill();
        t_chan();
        t_pdn();
        t_ser();
        t_ser_load();
        t_reset();
        conclude();
    end
endmodule
